//--- inc/iopr_cfg.svh
// Constants of the I/O processor register bank: offsets, widths, reset values, identification field.
// Included by the package; assumes nothing else.
`ifndef IOPR_CFG_SVH
`define IOPR_CFG_SVH
// Bus geometry
`define IOPR_AW          8
`define IOPR_DW          48
`define IOPR_NREG        256
// System control and buffer offsets (word index)
`define IOPR_SYSTEM_CONFIG      8'h00
`define IOPR_VECTOR_INTERRUPT       8'h01
`define IOPR_WAIT        8'h02
`define IOPR_SYSTEM_STATUS      8'h03
`define IOPR_EPB0        8'h04
`define IOPR_EXT_PORT_FIFO_1        8'h05
`define IOPR_MSG0        8'h08
`define IOPR_MSG7        8'h0F
`define IOPR_BUS_TIMEOUT_LIMIT        8'h18
`define IOPR_BUS_TIMEOUT_COUNT        8'h19
`define IOPR_DMAC0       8'h1C
`define IOPR_EXT_DMA_CONTROL_1       8'h1D
`define IOPR_SDRAM_REFRESH_DIVISOR      8'h20
`define IOPR_TPERIOD0    8'h28
`define IOPR_GPIO_SDRAM_CONTROL       8'h2E
`define IOPR_GPIO_PORT_STATUS      8'h2F
`define IOPR_DMA_CHANNEL_STATUS     8'h37
// DMA parameter area: eight words per channel block
`define IOPR_DA_FIRST    8'h30
`define IOPR_DA_LAST     8'h7F
`define IOPR_DA_CH7      5'h0B
`define IOPR_DA_CH8      5'h08
`define IOPR_DA_CH9      5'h09
`define IOPR_DA_CH6      5'h0F
`define IOPR_DA_LAST_STD 3'h4
// Serial port area: sixteen words per port, fourteen used
`define IOPR_SP_FIRST    8'h80
`define IOPR_SP_LAST     8'h9F
`define IOPR_SP_USED     4'hE
// Register widths
`define IOPR_W_SC        32
`define IOPR_W_BUS_TIMEOUT_COUNT      16
`define IOPR_W_EPB       48
`define IOPR_W_EXT_DMA_CONTROL      16
`define IOPR_W_DA_NARROW 18
`define IOPR_W_DA_WIDE   32
// Reset values
`define IOPR_RST_SYSTEM_CONFIG  32'h0000_0020
`define IOPR_RST_WAIT    32'h200D_6B5A
`define IOPR_RST_VECTOR_INTERRUPT   32'h0000_8014
// Identification field inside system status
`define IOPR_ID_LSB      4
`define IOPR_ID_MSB      11
`endif

//--- inc/iopr_pkg.sv
// Types shared by the I/O processor register bank.
// Assumes iopr_cfg.svh on the include path.
`include "iopr_cfg.svh"
package iopr_pkg;
	// Contention groups, one-hot
	typedef enum logic [4:0]
	{
		GRP_NONE = 5'b00001,
		GRP_SC   = 5'b00010,
		GRP_DB   = 5'b00100,
		GRP_DA   = 5'b01000,
		GRP_SP   = 5'b10000
	} iopr_grp_t;

	typedef logic [`IOPR_DW-1:0] iopr_word_t;

	// Whole state of the bank
	typedef struct packed
	{
		iopr_word_t [`IOPR_NREG-1:0] regs;
		iopr_word_t                  ext_rd;
		iopr_word_t                  core_rd;
		iopr_word_t                  iob_rd;
		logic                        ext_ack;
		logic                        core_ack;
		logic                        iob_ack;
		logic [1:0]                  ident;
		logic [31:0]                 dma_stat;
		logic [31:0]                 system_config_eff;
		logic [31:0]                 wait_eff;
		logic [31:0]                 gpio_sdram_control_eff;
		logic [15:0]                 dmac0_p1;
		logic [15:0]                 ext_dma_control_1_p1;
		logic [15:0]                 dmac0_eff;
		logic [15:0]                 ext_dma_control_1_eff;
	} iopr_state_t;
endpackage

//--- design/iopr_bank.sv
// I/O processor register bank: memory-mapped control and data registers with three access ports
// (external master, core, I/O bus) and fixed-priority group arbitration.
// Assumes all inputs synchronous to CLK; requesters hold address and data while their wait is high.
//
// Functional notes
// RULE_01: Registers live in the internal map; an address reaches its register.
// RULE_02: The I/O bus port works on its own, never waiting for core flow; here it waits while a core access targets the same group.
// RULE_03: Core and an external bus master can both read and write registers.
// RULE_04: Same group same cycle: external master served, core waits until done.
// RULE_05: Key registers and full DMA channels sit in the low 16/32/64 words.
// RULE_06: System control registers are 32 bits; bus timeout counter is 16.
// RULE_07: External port buffers are 48 bits; their DMA controls are 16.
// RULE_08: Ten DMA channels with index, modify, count, chain, general; 8, 9 extra.
// RULE_09: Serial DMA channels 0-5 use narrow parameters; channels 6-9 up to 32.
// RULE_10: Each serial port has fourteen 32-bit control, data and key registers.
// RULE_11: Reset loads system config 0x20 and wait states 0x200D6B5A.
// RULE_12: Reset clears DMA control, port control/status and serial control.
// RULE_13: System status reads zero except bits 11:4 showing identification pins.
// RULE_14: All control and status bits are active high.
// RULE_15: Software should write zero into reserved bits.
// RULE_16: Core moves go through core registers, never straight from memory.
// RULE_17: Writes readable next cycle; controls act second cycle, packing third.
// RULE_18: Priority is external port, then core buses, then I/O bus.
// RULE_19: Registers fall into system control, buffer, address and serial groups.
// RULE_20: A held-off core access stalls and completes later unchanged.
`timescale 1ns/1ps
module iopr_bank
	import iopr_pkg::*;
#(
	parameter int DA_NARROW_W = `IOPR_W_DA_NARROW,
	parameter int DA_WIDE_W   = `IOPR_W_DA_WIDE
)
(
	// Clock, reset, enable
	input  wire logic                CLK,
	input  wire logic                RSTN,
	input  wire logic                CE,
	// External bus master port
	input  wire logic                EXT_REQ,
	input  wire logic                EXT_WE,
	input  wire logic [`IOPR_AW-1:0] EXT_ADDR,
	input  wire logic [`IOPR_DW-1:0] EXT_WDATA,
	output logic      [`IOPR_DW-1:0] EXT_RDATA,
	output logic                     EXT_ACK,
	// Core port (fed from core registers)
	input  wire logic                CORE_REQ,
	input  wire logic                CORE_WE,
	input  wire logic [`IOPR_AW-1:0] CORE_ADDR,
	input  wire logic [`IOPR_DW-1:0] CORE_WDATA,
	output logic      [`IOPR_DW-1:0] CORE_RDATA,
	output logic                     CORE_ACK,
	output logic                     CORE_WAIT,
	// I/O bus port
	input  wire logic                IOB_REQ,
	input  wire logic                IOB_WE,
	input  wire logic [`IOPR_AW-1:0] IOB_ADDR,
	input  wire logic [`IOPR_DW-1:0] IOB_WDATA,
	output logic      [`IOPR_DW-1:0] IOB_RDATA,
	output logic                     IOB_ACK,
	output logic                     IOB_WAIT,
	// Status inputs
	input  wire logic [1:0]          IDENT_PINS,
	input  wire logic [31:0]         DMA_STATUS,
	// Effective control outputs
	output logic      [31:0]         SYSTEM_CONFIG_OUT,
	output logic      [31:0]         WAIT_OUT,
	output logic      [31:0]         GPIO_SDRAM_CONTROL_OUT,
	output logic      [15:0]         DMAC0_OUT,
	output logic      [15:0]         EXT_DMA_CONTROL_1_OUT
);

	iopr_state_t q;
	iopr_state_t d;

	iopr_grp_t ext_grp;
	iopr_grp_t core_grp;
	iopr_grp_t iob_grp;
	logic      ext_go;
	logic      core_go;
	logic      iob_go;

	// Mask of the low w bits
	function automatic iopr_word_t mask_of(input int w);
		mask_of = `IOPR_DW'((49'h1 << w) - 49'h1);
	endfunction

	// Contention group of an address
	// RULE_19: four contention groups
	function automatic iopr_grp_t grp_of(input logic [`IOPR_AW-1:0] a);
		if (a == `IOPR_EPB0 || a == `IOPR_EXT_PORT_FIFO_1 || a == `IOPR_DMAC0 || a == `IOPR_EXT_DMA_CONTROL_1)
			grp_of = GRP_DB;
		else if (a == `IOPR_DMA_CHANNEL_STATUS)
			grp_of = GRP_SC;
		else if (a >= `IOPR_DA_FIRST && a <= `IOPR_DA_LAST)
			grp_of = GRP_DA;
		else if (a >= `IOPR_SP_FIRST && a <= `IOPR_SP_LAST)
			grp_of = GRP_SP;
		else if (a <= `IOPR_GPIO_PORT_STATUS)
			grp_of = GRP_SC;
		else
			grp_of = GRP_NONE;
	endfunction

	// Implemented bits of an address; zero for unmapped words
	function automatic iopr_word_t wmask(input logic [`IOPR_AW-1:0] a);
		logic [4:0] blk;
		logic [2:0] off;
		logic       ep;
		logic       wide;
		blk   = a[7:3];
		off   = a[2:0];
		ep    = (blk == `IOPR_DA_CH8) || (blk == `IOPR_DA_CH9);
		wide  = ep || (blk == `IOPR_DA_CH6) || (blk == `IOPR_DA_CH7);
		wmask = '0;
		// RULE_05: key registers sit in the lowest words
		// RULE_06: system control widths
		if (a <= `IOPR_SYSTEM_STATUS || a == `IOPR_DMA_CHANNEL_STATUS || a == `IOPR_BUS_TIMEOUT_LIMIT || a == `IOPR_SDRAM_REFRESH_DIVISOR)
			wmask = mask_of(`IOPR_W_SC);
		else if (a >= `IOPR_MSG0 && a <= `IOPR_MSG7)
			wmask = mask_of(`IOPR_W_SC);
		else if (a >= `IOPR_TPERIOD0 && a <= `IOPR_GPIO_PORT_STATUS)
			wmask = mask_of(`IOPR_W_SC);
		else if (a == `IOPR_BUS_TIMEOUT_COUNT)
			wmask = mask_of(`IOPR_W_BUS_TIMEOUT_COUNT);
		// RULE_07: buffer and buffer control widths
		else if (a == `IOPR_EPB0 || a == `IOPR_EXT_PORT_FIFO_1)
			wmask = mask_of(`IOPR_W_EPB);
		else if (a == `IOPR_DMAC0 || a == `IOPR_EXT_DMA_CONTROL_1)
			wmask = mask_of(`IOPR_W_EXT_DMA_CONTROL);
		// RULE_08: five parameters per channel, eight on channels 8 and 9
		else if (a >= `IOPR_DA_FIRST && a <= `IOPR_DA_LAST && (ep || off <= `IOPR_DA_LAST_STD))
		begin
			// RULE_09: narrow serial channels, wide others
			wmask = wide ? mask_of(DA_WIDE_W) : mask_of(DA_NARROW_W);
		end
		// RULE_10: serial port registers
		else if (a >= `IOPR_SP_FIRST && a <= `IOPR_SP_LAST && a[3:0] < `IOPR_SP_USED)
			wmask = mask_of(`IOPR_W_SC);
	endfunction

	// Writable unless unmapped or a read-only status word
	function automatic logic writable(input logic [`IOPR_AW-1:0] a);
		writable = (wmask(a) != '0) && (a != `IOPR_SYSTEM_STATUS) && (a != `IOPR_DMA_CHANNEL_STATUS);
	endfunction

	// Read value of an address from current state
	function automatic iopr_word_t rd_word(input logic [`IOPR_AW-1:0] a);
		rd_word = '0;
		if (a == `IOPR_SYSTEM_STATUS)
		begin
			// RULE_13: identification field, rest zero
			rd_word[`IOPR_ID_MSB:`IOPR_ID_LSB] = 8'(q.ident);
		end
		else if (a == `IOPR_DMA_CHANNEL_STATUS)
			rd_word[31:0] = q.dma_stat;
		else
			rd_word = q.regs[a] & wmask(a);
	endfunction

	// Group decode of each requester
	assign ext_grp  = grp_of(EXT_ADDR);
	assign core_grp = grp_of(CORE_ADDR);
	assign iob_grp  = grp_of(IOB_ADDR);

	// Arbitration: external never waits
	// RULE_18: fixed priority external, core, I/O bus
	// RULE_04: core held off on a shared group
	assign CORE_WAIT = CORE_REQ && EXT_REQ && (core_grp == ext_grp) && (core_grp != GRP_NONE);
	// RULE_02: I/O bus waits only on a real group clash; buffers are shared with the external port
	assign IOB_WAIT  = IOB_REQ && (iob_grp != GRP_NONE) &&
	                   ((EXT_REQ && ext_grp == iob_grp && iob_grp != GRP_DB) ||
	                    (CORE_REQ && core_grp == iob_grp));
	// RULE_03: both masters reach the bank
	assign ext_go  = CE && EXT_REQ;
	// RULE_20: stalled core request is taken later as held
	assign core_go = CE && CORE_REQ && !CORE_WAIT;
	assign iob_go  = CE && IOB_REQ && !IOB_WAIT;

	// Next state: writes, read captures, control pipelines
	always_comb
	begin
		d          = q;
		d.ext_ack  = ext_go;
		d.core_ack = core_go;
		d.iob_ack  = iob_go;
		// Status levels sampled every enabled cycle
		d.ident    = IDENT_PINS;
		d.dma_stat = DMA_STATUS;
		// Reads see the value before this cycle's writes
		if (ext_go && !EXT_WE)
			d.ext_rd = rd_word(EXT_ADDR);
		if (core_go && !CORE_WE)
			d.core_rd = rd_word(CORE_ADDR);
		if (iob_go && !IOB_WE)
			d.iob_rd = rd_word(IOB_ADDR);
		// RULE_01: address decode of writes; later lines win
		if (iob_go && IOB_WE && writable(IOB_ADDR))
			d.regs[IOB_ADDR] = IOB_WDATA & wmask(IOB_ADDR);
		// RULE_16: core data arrives from core registers
		if (core_go && CORE_WE && writable(CORE_ADDR))
			d.regs[CORE_ADDR] = CORE_WDATA & wmask(CORE_ADDR);
		if (ext_go && EXT_WE && writable(EXT_ADDR))
			d.regs[EXT_ADDR] = EXT_WDATA & wmask(EXT_ADDR);
		// RULE_17: controls act one stage after the stored value
		d.system_config_eff = q.regs[`IOPR_SYSTEM_CONFIG][31:0];
		d.wait_eff   = q.regs[`IOPR_WAIT][31:0];
		d.gpio_sdram_control_eff  = q.regs[`IOPR_GPIO_SDRAM_CONTROL][31:0];
		// RULE_17: packing and flush controls two stages after
		d.dmac0_p1   = q.regs[`IOPR_DMAC0][15:0];
		d.ext_dma_control_1_p1   = q.regs[`IOPR_EXT_DMA_CONTROL_1][15:0];
		d.dmac0_eff  = q.dmac0_p1;
		d.ext_dma_control_1_eff  = q.ext_dma_control_1_p1;
	end

	// State register; enable freezes everything
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			// RULE_12: controls and status cleared
			q <= '0;
			// RULE_11: configuration and wait state defaults
			q.regs[`IOPR_SYSTEM_CONFIG] <= `IOPR_DW'(`IOPR_RST_SYSTEM_CONFIG);
			q.regs[`IOPR_WAIT]   <= `IOPR_DW'(`IOPR_RST_WAIT);
			q.regs[`IOPR_VECTOR_INTERRUPT]  <= `IOPR_DW'(`IOPR_RST_VECTOR_INTERRUPT);
			q.system_config_eff         <= `IOPR_RST_SYSTEM_CONFIG;
			q.wait_eff           <= `IOPR_RST_WAIT;
		end
		else if (CE)
		begin
			q <= d;
		end
	end

	// Registered outputs
	// RULE_14: all bits active high
	assign EXT_RDATA  = q.ext_rd;
	assign EXT_ACK    = q.ext_ack;
	assign CORE_RDATA = q.core_rd;
	assign CORE_ACK   = q.core_ack;
	assign IOB_RDATA  = q.iob_rd;
	assign IOB_ACK    = q.iob_ack;
	assign SYSTEM_CONFIG_OUT = q.system_config_eff;
	assign WAIT_OUT   = q.wait_eff;
	assign GPIO_SDRAM_CONTROL_OUT  = q.gpio_sdram_control_eff;
	assign DMAC0_OUT  = q.dmac0_eff;
	assign EXT_DMA_CONTROL_1_OUT  = q.ext_dma_control_1_eff;

endmodule

//--- dv/iopr_bank_asserts.sv
// Port timing checker for the register bank.
// Assumes it is bound onto iopr_bank and that requests change only off the rising edge.
`timescale 1ns/1ps
`include "iopr_cfg.svh"
module iopr_bank_chk
(
	// Clock and reset
	input wire logic        CLK,
	input wire logic        RSTN,
	input wire logic        CE,
	// External port
	input wire logic        EXT_REQ,
	input wire logic        EXT_WE,
	input wire logic [7:0]  EXT_ADDR,
	input wire logic [47:0] EXT_WDATA,
	input wire logic        EXT_ACK,
	// Core and I/O bus handshakes
	input wire logic        CORE_REQ,
	input wire logic        CORE_ACK,
	input wire logic        CORE_WAIT,
	input wire logic        IOB_REQ,
	input wire logic        IOB_ACK,
	input wire logic        IOB_WAIT,
	// Effective controls
	input wire logic [31:0] SYSTEM_CONFIG_OUT,
	input wire logic [31:0] WAIT_OUT,
	input wire logic [15:0] DMAC0_OUT
);
	// One clock domain
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	property p_ext_ack; CE && EXT_REQ |=> EXT_ACK; endproperty
	a_ext_ack: assert property (p_ext_ack) else $error("external ack missing");
	property p_ext_idle; CE && !EXT_REQ |=> !EXT_ACK; endproperty
	a_ext_idle: assert property (p_ext_idle) else $error("external ack without request");
	property p_core_ack; CE && CORE_REQ && !CORE_WAIT |=> CORE_ACK; endproperty
	a_core_ack: assert property (p_core_ack) else $error("core ack missing");
	property p_core_hold; CE && CORE_REQ && CORE_WAIT |=> !CORE_ACK; endproperty
	a_core_hold: assert property (p_core_hold) else $error("core served while held");
	property p_core_cause; CORE_WAIT |-> EXT_REQ; endproperty
	a_core_cause: assert property (p_core_cause) else $error("core held with no external access");
	property p_iob_ack; CE && IOB_REQ && !IOB_WAIT |=> IOB_ACK; endproperty
	a_iob_ack: assert property (p_iob_ack) else $error("I/O bus ack missing");
	property p_iob_cause; IOB_WAIT |-> EXT_REQ || CORE_REQ; endproperty
	a_iob_cause: assert property (p_iob_cause) else $error("I/O bus held with no rival");
	property p_sc_lat;
		CE && EXT_REQ && EXT_WE && EXT_ADDR == `IOPR_SYSTEM_CONFIG |-> ##2 SYSTEM_CONFIG_OUT == $past(EXT_WDATA[31:0], 2);
	endproperty
	a_sc_lat: assert property (p_sc_lat) else $error("config control late or wrong");
	property p_ext_dma_control_lat;
		CE && EXT_REQ && EXT_WE && EXT_ADDR == `IOPR_DMAC0 |-> ##3 DMAC0_OUT == $past(EXT_WDATA[15:0], 3);
	endproperty
	a_ext_dma_control_lat: assert property (p_ext_dma_control_lat) else $error("DMA control late or wrong");
	property p_rst_val; $rose(RSTN) |-> SYSTEM_CONFIG_OUT == 32'h20 && WAIT_OUT == 32'h200D6B5A && DMAC0_OUT == 16'h0;
	endproperty
	a_rst_val: assert property (p_rst_val) else $error("control reset value wrong");
endmodule
bind iopr_bank iopr_bank_chk u_iopr_bank_chk (.CLK(CLK), .RSTN(RSTN), .CE(CE), .EXT_REQ(EXT_REQ), .EXT_WE(EXT_WE),
	.EXT_ADDR(EXT_ADDR), .EXT_WDATA(EXT_WDATA), .EXT_ACK(EXT_ACK), .CORE_REQ(CORE_REQ), .CORE_ACK(CORE_ACK),
	.CORE_WAIT(CORE_WAIT), .IOB_REQ(IOB_REQ), .IOB_ACK(IOB_ACK), .IOB_WAIT(IOB_WAIT), .SYSTEM_CONFIG_OUT(SYSTEM_CONFIG_OUT),
	.WAIT_OUT(WAIT_OUT), .DMAC0_OUT(DMAC0_OUT));

//--- dv/iopr_ext_master.sv
// External bus master model on the bank's external port.
// Assumes the bank takes a request at the first rising edge and acks one cycle later.
`timescale 1ns/1ps
module iopr_ext_master
(
	// Clock
	input  wire logic        clk,
	// Request side
	output logic             req,
	output logic             we,
	output logic [7:0]       addr,
	output logic [47:0]      wdata,
	// Answer side
	input  wire logic [47:0] rdata,
	input  wire logic        ack
);
	// Idle bus at time zero
	initial
	begin
		{req, we, addr, wdata} = {1'b0, 1'b0, 8'hFF, 48'h0};
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [47:0] d, input int gap,
		output logic [47:0] q, output logic k);
		repeat (gap) @(negedge clk);
		{req, we, addr, wdata} = {1'b1, w, a, d};
		@(negedge clk);
		k = ack;
		q = rdata;
		// Released lines show the inverse of the last value
		{req, we, addr, wdata} = {1'b0, ~w, ~a, ~d};
		// Let one edge pass so a following call never re-raises req in the same step
		@(negedge clk);
	endtask
endmodule

//--- dv/iopr_bank_tb_top.sv
// Testbench of the register bank: core, I/O bus and external master traffic.
// Assumes the external master model sits on the external port.
`timescale 1ns/1ps
module iopr_bank_tb_top;
	// Design inputs
	logic        CLK, RSTN, CE, CORE_REQ, CORE_WE, IOB_REQ, IOB_WE;
	logic [7:0]  CORE_ADDR, IOB_ADDR;
	logic [47:0] CORE_WDATA, IOB_WDATA;
	logic [1:0]  IDENT_PINS;
	logic [31:0] DMA_STATUS;
	// Design outputs and master lines
	logic        EXT_REQ, EXT_WE, EXT_ACK, CORE_ACK, CORE_WAIT, IOB_ACK, IOB_WAIT;
	logic [7:0]  EXT_ADDR;
	logic [47:0] EXT_WDATA, EXT_RDATA, CORE_RDATA, IOB_RDATA;
	logic [31:0] SYSTEM_CONFIG_OUT, WAIT_OUT, GPIO_SDRAM_CONTROL_OUT;
	logic [15:0] DMAC0_OUT, EXT_DMA_CONTROL_1_OUT;
	int          err_count, checks_done;
	bit          saw_cw, saw_iw, k;
	logic [47:0] q, q2;
	iopr_bank u_iopr_bank (.CLK(CLK), .RSTN(RSTN), .CE(CE), .EXT_REQ(EXT_REQ), .EXT_WE(EXT_WE), .EXT_ADDR(EXT_ADDR),
		.EXT_WDATA(EXT_WDATA), .EXT_RDATA(EXT_RDATA), .EXT_ACK(EXT_ACK), .CORE_REQ(CORE_REQ), .CORE_WE(CORE_WE),
		.CORE_ADDR(CORE_ADDR), .CORE_WDATA(CORE_WDATA), .CORE_RDATA(CORE_RDATA), .CORE_ACK(CORE_ACK),
		.CORE_WAIT(CORE_WAIT), .IOB_REQ(IOB_REQ), .IOB_WE(IOB_WE), .IOB_ADDR(IOB_ADDR), .IOB_WDATA(IOB_WDATA),
		.IOB_RDATA(IOB_RDATA), .IOB_ACK(IOB_ACK), .IOB_WAIT(IOB_WAIT), .IDENT_PINS(IDENT_PINS),
		.DMA_STATUS(DMA_STATUS), .SYSTEM_CONFIG_OUT(SYSTEM_CONFIG_OUT), .WAIT_OUT(WAIT_OUT), .GPIO_SDRAM_CONTROL_OUT(GPIO_SDRAM_CONTROL_OUT),
		.DMAC0_OUT(DMAC0_OUT), .EXT_DMA_CONTROL_1_OUT(EXT_DMA_CONTROL_1_OUT));
	iopr_ext_master m_ext (.clk(CLK), .req(EXT_REQ), .we(EXT_WE), .addr(EXT_ADDR), .wdata(EXT_WDATA),
		.rdata(EXT_RDATA), .ack(EXT_ACK));
	// Clock, 100 ns period
	initial
	begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	// Note any hold-off seen on the core or I/O bus
	always @(posedge CLK)
	begin
		if (CORE_WAIT === 1'b1) saw_cw = 1'b1;
		if (IOB_WAIT === 1'b1) saw_iw = 1'b1;
	end
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	// Core (p=0) or I/O bus (p=1) access, held while its wait is high
	task automatic acc(input bit p, input logic w, input logic [7:0] a, input logic [47:0] d, output logic [47:0] r);
		int n;
		n = 0;
		if (p) {IOB_REQ, IOB_WE, IOB_ADDR, IOB_WDATA} = {1'b1, w, a, d};
		else {CORE_REQ, CORE_WE, CORE_ADDR, CORE_WDATA} = {1'b1, w, a, d};
		do
		begin
			@(posedge CLK);
			n++;
		end
		while ((p ? IOB_WAIT : CORE_WAIT) !== 1'b0 && n < 20);
		@(negedge CLK);
		chk("ack", 48'h1, {47'h0, p ? IOB_ACK : CORE_ACK});
		r = p ? IOB_RDATA : CORE_RDATA;
		if (p) {IOB_REQ, IOB_WE, IOB_ADDR, IOB_WDATA} = {1'b0, ~w, ~a, ~d};
		else {CORE_REQ, CORE_WE, CORE_ADDR, CORE_WDATA} = {1'b0, ~w, ~a, ~d};
		// Idle edge between back-to-back calls
		@(negedge CLK);
	endtask
	task automatic t_reset();
		logic [7:0]  ra [10] = '{8'h00, 8'h02, 8'h01, 8'h2E, 8'h2F, 8'h1C, 8'h80, 8'h91, 8'h03, 8'h37};
		logic [47:0] rv [10] = '{48'h20, 48'h200D6B5A, 48'h8014, 48'h0, 48'h0, 48'h0, 48'h0, 48'h0, 48'h20, 48'h5A5A0F0F};
		chk("gpio_sdram_control_out", 48'h0, {16'h0, GPIO_SDRAM_CONTROL_OUT});
		chk("ext_dma_control_1_out", 48'h0, {32'h0, EXT_DMA_CONTROL_1_OUT});
		chk("wait_out", 48'h200D6B5A, {16'h0, WAIT_OUT});
		for (int i = 0; i < 10; i++)
		begin
			acc(i[0], 1'b0, ra[i], 48'h0, q);
			chk("reset_read", rv[i], q);
		end
	endtask
	task automatic t_map();
		logic [7:0]  ma [11] = '{8'h08, 8'h19, 8'h04, 8'h1D, 8'h30, 8'h40, 8'h58, 8'h8D, 8'h06, 8'h03, 8'h8E};
		logic [47:0] mv [11] = '{48'hFFFFFFFF, 48'hFFFF, 48'hFFFFFFFFFFFF, 48'hFFFF, 48'h3FFFF, 48'hFFFFFFFF,
			48'hFFFFFFFF, 48'hFFFFFFFF, 48'h0, 48'h20, 48'h0};
		for (int i = 0; i < 11; i++)
		begin
			acc(i[0], 1'b1, ma[i], 48'hFFFFFFFFFFFF, q);
			acc(~i[0], 1'b0, ma[i], 48'h0, q);
			chk("width_read", mv[i], q);
		end
	endtask
	task automatic t_latency();
		m_ext.xfer(1'b1, 8'h00, 48'h21, 0, q, k); // reserved bits written as zero
		acc(1'b0, 1'b0, 8'h00, 48'h0, q);
		chk("system_config_read", 48'h21, q);
		chk("system_config_out", 48'h21, {16'h0, SYSTEM_CONFIG_OUT});
		m_ext.xfer(1'b1, 8'h1C, 48'h3, 0, q, k);
		chk("dmac0_early", 48'h0, {32'h0, DMAC0_OUT});
		@(negedge CLK);
		chk("dmac0_out", 48'h3, {32'h0, DMAC0_OUT});
	endtask
	task automatic t_stall();
		saw_cw = 1'b0;
		fork
			m_ext.xfer(1'b1, 8'h09, 48'hA1, 0, q, k);
			acc(1'b0, 1'b1, 8'h09, 48'hB2, q2);
		join
		chk("core_held", 48'h1, {47'h0, saw_cw});
		acc(1'b1, 1'b0, 8'h09, 48'h0, q);
		chk("stalled_write", 48'hB2, q);
		fork
			m_ext.xfer(1'b1, 8'h0A, 48'hC3, 1, q, k);
			acc(1'b0, 1'b1, 8'h0A, 48'hD4, q2);
		join
		m_ext.xfer(1'b0, 8'h0A, 48'h0, 0, q, k);
		chk("ext_ack", 48'h1, {47'h0, k});
		chk("ext_read", 48'hC3, q);
	endtask
	task automatic t_iob();
		saw_iw = 1'b0;
		fork
			m_ext.xfer(1'b1, 8'h05, 48'hE5E5_0000_1111, 0, q, k);
			acc(1'b1, 1'b1, 8'h04, 48'h1234_5678_9ABC, q2);
		join
		chk("buffer_shared", 48'h0, {47'h0, saw_iw});
		fork
			acc(1'b0, 1'b1, 8'h31, 48'h11, q);
			acc(1'b1, 1'b1, 8'h32, 48'h22, q2);
		join
		chk("iob_yields", 48'h1, {47'h0, saw_iw});
		acc(1'b0, 1'b0, 8'h05, 48'h0, q);
		chk("ext_buffer", 48'hE5E5_0000_1111, q);
		acc(1'b1, 1'b0, 8'h32, 48'h0, q);
		chk("iob_late_write", 48'h22, q);
	endtask
	task automatic results();
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial
	begin
		repeat (3000) @(posedge CLK);
		err_count++;
		results();
	end
	// Main sequence
	initial
	begin
		{RSTN, CE, CORE_REQ, CORE_WE, IOB_REQ, IOB_WE} = 6'b010000;
		{CORE_ADDR, IOB_ADDR, CORE_WDATA, IOB_WDATA} = '0;
		IDENT_PINS = 2'b10;
		DMA_STATUS = 32'h5A5A0F0F;
		repeat (8) @(negedge CLK);
		RSTN = 1'b1;
		t_reset();
		t_map();
		t_latency();
		t_stall();
		t_iob();
		results();
	end
endmodule
